//--- verilog/cpkl_pkg.sv
// constants and carrier types for the cipher port and key loader
`default_nettype none
package cpkl_pkg;
  // register byte addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_INSTR = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_IRQ   = 8'h0C;
  localparam logic [7:0] A_MASK  = 8'h10;
  localparam logic [7:0] A_ISRH  = 8'h14;
  localparam logic [7:0] A_ISRL  = 8'h18;
  localparam logic [7:0] A_OSRH  = 8'h1C;
  localparam logic [7:0] A_OSRL  = 8'h20;
  localparam logic [7:0] A_KEYH  = 8'h24;
  localparam logic [7:0] A_KEYL  = 8'h28;
  // port configuration bits
  localparam int C_ISR_SLV = 0;
  localparam int C_OSR_SLV = 1;
  localparam int C_S_SER   = 2;
  localparam int C_M_SER   = 3;
  localparam int C_KEY_PAR = 4;
  localparam int CTRL_W    = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // microcode instruction bits
  localparam int I_SERIAL = 0;
  localparam int I_ACT    = 1;
  localparam int I_END    = 2;
  localparam int I_CLISRF = 3;
  localparam int INSTR_W  = 4;
  // status byte bits
  localparam int S_KREQ = 3;
  localparam int S_ISRF = 4;
  localparam int S_OSRE = 5;
  localparam int S_ACT  = 6;
  localparam int S_PF   = 7;
  // interrupt event bits
  localparam int E_ISRF = 0;
  localparam int E_OSRE = 1;
  localparam int E_KEYD = 2;
  localparam int E_PF   = 3;
  localparam int EV_W   = 4;
  // sizes and counts
  localparam logic [6:0] SR_BITS  = 7'h40;
  localparam logic [6:0] KEY_CLKS = 7'h40;
  localparam logic [6:0] KEY_BYTES = 7'h08;
  localparam int KEY_BITS = 56;
  typedef struct packed {
    logic       s_wr_n;
    logic       s_rd_n;
    logic       m_wr_n;
    logic       m_rd_n;
    logic       k_clk;
    logic       k_dat;
    logic       s_sel_n;
    logic       s_addr;
    logic       s_ser;
    logic       m_ser;
    logic [2:0] m_addr;
    logic [7:0] s_par;
    logic [7:0] m_par;
  } cpkl_pins_t;
endpackage
`default_nettype wire

//--- verilog/cpkl_top.sv
// port, serial key entry and flag logic of the cipher processor
//
// Implementation choices: the address map and register access over AHB-Lite.
`default_nettype none
// Summary of operation
// RULE_01: key_request_n low while waiting for key; set by serial+act; in status.
// RULE_02: active output high, set only by the act instruction.
// RULE_03: parity_fail_n low if any key byte had even parity; in status.
// RULE_04: parity flag updated on 8th master write or 64th serial key clock.
// RULE_05: one microcode instruction executes every two clocks.
// RULE_06: host strobes are asynchronous to clk and still accepted.
// RULE_07: serial pins shift into input or out of output register per config.
// RULE_08: serial pins carry most significant bit first.
// RULE_09: slave serial uses slave strobes and flag, reaches only shift registers.
// RULE_10: master serial active only when selected and master address 0.
// RULE_11: serial key bit latched on each falling key clock edge.
// RULE_12: key entered msb first; every 8th bit is odd parity of seven.
// RULE_13: parity error only flags; full 56-bit key still loaded.
// RULE_14: slave 8-bit parallel bus writes input, reads output and status.
// RULE_15: serial key input ignored after 64 key clocks.
// RULE_16: slave select high tri-states all slave port outputs; the code gates only the bus and serial drives, slave_flag stays driven.
// RULE_17: every async strobe passes two flops and edge detection.
// RULE_18: parity over each 8-bit group; even count of ones latches fail.
module cpkl_top (
  input  wire logic        clk,              // 20 MHz clock
  input  wire logic        nrst,             // async reset, active low
  input  wire logic        hsel,             // ahb select
  input  wire logic [31:0] haddr,            // ahb address
  input  wire logic [1:0]  htrans,           // ahb transfer type
  input  wire logic        hwrite,           // ahb write
  input  wire logic [2:0]  hsize,            // ahb size
  input  wire logic [31:0] hwdata,           // ahb write data
  input  wire logic        hready,           // ahb bus ready
  output logic [31:0]      hrdata,           // ahb read data
  output logic             hreadyout,        // ahb slave ready
  output logic             hresp,            // ahb response
  output logic             irq,              // level interrupt
  input  wire logic        slave_wr_n,       // slave write strobe
  input  wire logic        slave_rd_n,       // slave read strobe
  input  wire logic        slave_select_n,   // slave chip select
  input  wire logic        slave_addr,       // slave register address
  output logic             slave_flag,       // slave shift flag
  input  wire logic [7:0]  slave_par_bus_i,  // slave bus in
  output logic [7:0]       slave_par_bus_o,  // slave bus out
  output logic             slave_par_bus_oe, // slave bus drive
  input  wire logic        slave_serial_io_i, // slave serial in
  output logic             slave_serial_io_o, // slave serial out
  output logic             slave_serial_io_oe, // slave serial drive
  input  wire logic        master_wr_n,      // master write strobe
  input  wire logic        master_rd_n,      // master read strobe
  input  wire logic [2:0]  master_addr,      // master register address
  input  wire logic [7:0]  master_par_in,    // master bus in
  output logic             master_flag_a,    // master flag a
  output logic             master_flag_b,    // master flag b
  input  wire logic        master_serial_io_i, // master serial in
  output logic             master_serial_io_o, // master serial out
  output logic             master_serial_io_oe, // master serial drive
  input  wire logic        key_serial_in,    // serial key data
  input  wire logic        key_serial_clk,   // serial key clock
  output logic             key_request_n,    // key request, active low
  output logic             active,           // activity flag
  output logic             parity_fail_n     // parity fail, active low
);
  cpkl_pkg::cpkl_pins_t raw, s1_q, s2_q, pv_q;
  assign raw = '{slave_wr_n, slave_rd_n, master_wr_n, master_rd_n, key_serial_clk,
                 key_serial_in, slave_select_n, slave_addr, slave_serial_io_i,
                 master_serial_io_i, master_addr, slave_par_bus_i, master_par_in};

  // two-flop synchroniser; edges are taken from the second stage only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= '1;
      s2_q <= '1;
      pv_q <= '1;
    end
    else
    begin
      s1_q <= raw;  // RULE_17
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  logic sel, s_wr, s_rd_end, m_wr, m_rd_end, k_fall, m_a0;
  assign sel      = !s2_q.s_sel_n;
  assign m_a0     = (s2_q.m_addr == 3'h0);  // RULE_10
  assign s_wr     = s2_q.s_wr_n & !pv_q.s_wr_n & sel;  // RULE_06
  assign s_rd_end = s2_q.s_rd_n & !pv_q.s_rd_n & sel;
  assign m_wr     = s2_q.m_wr_n & !pv_q.m_wr_n & m_a0;
  assign m_rd_end = s2_q.m_rd_n & !pv_q.m_rd_n & m_a0;
  assign k_fall   = !s2_q.k_clk & pv_q.k_clk;  // RULE_11

  ////////////////////////////////////////////////////////////////
  logic [cpkl_pkg::CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [cpkl_pkg::INSTR_W-1:0] instr_q, instr_d;
  logic [cpkl_pkg::EV_W-1:0]    irq_q, irq_d, mask_q, mask_d, ev;
  logic [63:0] isr_q, isr_d, osr_q, osr_d;
  logic [31:0] osrh_q, osrh_d, hrdata_q, hrdata_d;
  logic [cpkl_pkg::KEY_BITS-1:0] key_q, key_d;
  logic [6:0]  icnt_q, icnt_d, ocnt_q, ocnt_d, kcnt_q, kcnt_d;
  logic [7:0]  wa_q, wa_d, spo_q, spo_d, stat;
  logic pend_q, pend_d, ph_q, ph_d, kreq_q, kreq_d, act_q, act_d;
  logic pf_q, pf_d, bad_q, bad_d, gpar_q, gpar_d, isrf_q, isrf_d;
  logic osre_q, osre_d, wr_q, wr_d;
  logic exec, isr_wr, ser_in, in_bit, osr_rd, k_take, p_take, grp_end, pf_upd, wsel;

  assign exec = ph_q & pend_q;  // RULE_05
  assign wsel = hsel & htrans[1] & hready;
  assign stat = {pf_q, act_q, osre_q, isrf_q, kreq_q, 3'h0};  // RULE_01

  // input register source: slave or master, serial or parallel
  always_comb
  begin
    if (ctrl_q[cpkl_pkg::C_ISR_SLV])
    begin
      isr_wr = s_wr & (ctrl_q[cpkl_pkg::C_S_SER] | !s2_q.s_addr);  // RULE_09 RULE_14
      ser_in = ctrl_q[cpkl_pkg::C_S_SER];
      in_bit = s2_q.s_ser;
    end
    else
    begin
      isr_wr = m_wr & !ctrl_q[cpkl_pkg::C_KEY_PAR];  // RULE_10
      ser_in = ctrl_q[cpkl_pkg::C_M_SER];
      in_bit = s2_q.m_ser;
    end
  end

  assign osr_rd = ctrl_q[cpkl_pkg::C_OSR_SLV] ? s_rd_end & (ctrl_q[cpkl_pkg::C_S_SER]
                  | !s2_q.s_addr) : m_rd_end;
  assign k_take = k_fall & kreq_q & (kcnt_q < cpkl_pkg::KEY_CLKS);  // RULE_15
  assign p_take = m_wr & ctrl_q[cpkl_pkg::C_KEY_PAR] & (kcnt_q < cpkl_pkg::KEY_BYTES);
  assign grp_end = (kcnt_q[2:0] == 3'h7);
  assign pf_upd = (k_take & (kcnt_q == cpkl_pkg::KEY_CLKS - 7'h01))
                | (p_take & (kcnt_q == cpkl_pkg::KEY_BYTES - 7'h01));  // RULE_04

  always_comb
  begin
    ctrl_d = ctrl_q;
    instr_d = instr_q;
    pend_d = pend_q & !exec;
    ph_d = !ph_q;
    kreq_d = kreq_q;
    act_d = act_q;
    pf_d = pf_q;
    bad_d = bad_q;
    gpar_d = gpar_q;
    key_d = key_q;
    kcnt_d = kcnt_q;
    isr_d = isr_q;
    icnt_d = icnt_q;
    isrf_d = isrf_q;
    osr_d = osr_q;
    ocnt_d = ocnt_q;
    osre_d = osre_q;
    osrh_d = osrh_q;
    mask_d = mask_q;
    ev = '0;
    wa_d = wsel ? haddr[7:0] : wa_q;
    wr_d = wsel & hwrite;
    hrdata_d = hrdata_q;
    spo_d = s2_q.s_addr ? stat : osr_q[63:56];  // RULE_14
    if (exec)
    begin
      if (instr_q[cpkl_pkg::I_SERIAL] & instr_q[cpkl_pkg::I_ACT])
      begin
        kreq_d = 1'b1;  // RULE_01
        kcnt_d = '0;
        bad_d = 1'b0;
        gpar_d = 1'b0;
      end
      if (instr_q[cpkl_pkg::I_ACT])
        act_d = 1'b1;  // RULE_02
      if (instr_q[cpkl_pkg::I_END])
      begin
        kreq_d = 1'b0;
        act_d = 1'b0;
      end
      if (instr_q[cpkl_pkg::I_CLISRF])
      begin
        isrf_d = 1'b0;
        icnt_d = '0;
      end
    end
    // serial key: seven data bits kept, eighth checked as odd parity
    if (k_take)
    begin
      kcnt_d = kcnt_q + 7'h01;
      gpar_d = gpar_q ^ s2_q.k_dat;
      if (grp_end)
      begin
        gpar_d = 1'b0;
        bad_d = bad_q | !(gpar_q ^ s2_q.k_dat);  // RULE_12 RULE_18
      end
      else
        key_d = {key_q[54:0], s2_q.k_dat};  // RULE_08 RULE_13
      if (pf_upd)
      begin
        kreq_d = 1'b0;
        pf_d = bad_q | (grp_end & !(gpar_q ^ s2_q.k_dat));  // RULE_03
        ev[cpkl_pkg::E_KEYD] = 1'b1;
      end
    end
    // parallel key bytes from master writes
    if (p_take)
    begin
      kcnt_d = kcnt_q + 7'h01;
      key_d = {key_q[48:0], s2_q.m_par[7:1]};  // RULE_13
      bad_d = bad_q | !(^s2_q.m_par);  // RULE_18
      if (pf_upd)
      begin
        pf_d = bad_q | !(^s2_q.m_par);  // RULE_04
        ev[cpkl_pkg::E_KEYD] = 1'b1;
      end
    end
    ev[cpkl_pkg::E_PF] = pf_upd & pf_d;
    if (isr_wr & !isrf_q)
    begin
      if (ser_in)
      begin
        isr_d = {isr_q[62:0], in_bit};  // RULE_07 RULE_08
        icnt_d = icnt_q + 7'h01;
      end
      else
      begin
        isr_d = {isr_q[55:0], ctrl_q[cpkl_pkg::C_ISR_SLV] ? s2_q.s_par : s2_q.m_par};
        icnt_d = icnt_q + 7'h08;
      end
      if (icnt_d >= cpkl_pkg::SR_BITS)
      begin
        isrf_d = 1'b1;
        ev[cpkl_pkg::E_ISRF] = 1'b1;
      end
    end
    if (osr_rd & !osre_q)
    begin
      osr_d = ctrl_q[cpkl_pkg::C_OSR_SLV] & !ctrl_q[cpkl_pkg::C_S_SER]
              | !ctrl_q[cpkl_pkg::C_OSR_SLV] & !ctrl_q[cpkl_pkg::C_M_SER]
              ? {osr_q[55:0], 8'h00} : {osr_q[62:0], 1'b0};  // RULE_07
      // parallel read drains a byte, serial read one bit
      ocnt_d = ocnt_q + ((ctrl_q[cpkl_pkg::C_OSR_SLV] ? ctrl_q[cpkl_pkg::C_S_SER]
               : ctrl_q[cpkl_pkg::C_M_SER]) ? 7'h01 : 7'h08);
      if (ocnt_d >= cpkl_pkg::SR_BITS)
      begin
        osre_d = 1'b1;
        ev[cpkl_pkg::E_OSRE] = 1'b1;
      end
    end
    if (wr_q)
    begin
      unique case (wa_q)
        cpkl_pkg::A_CTRL:
        begin
          ctrl_d = hwdata[cpkl_pkg::CTRL_W-1:0];
          kcnt_d = '0;
          bad_d = 1'b0;
        end
        cpkl_pkg::A_INSTR:
        begin
          instr_d = hwdata[cpkl_pkg::INSTR_W-1:0];
          pend_d = 1'b1;
        end
        cpkl_pkg::A_MASK: mask_d = hwdata[cpkl_pkg::EV_W-1:0];
        cpkl_pkg::A_OSRH: osrh_d = hwdata;
        cpkl_pkg::A_OSRL:
        begin
          osr_d = {osrh_q, hwdata};
          ocnt_d = '0;
          osre_d = 1'b0;
        end
        default: ;
      endcase
    end
    // set wins over write-one-to-clear
    irq_d = (irq_q & ~((wr_q && wa_q == cpkl_pkg::A_IRQ) ? hwdata[cpkl_pkg::EV_W-1:0]
            : '0)) | ev;
    if (wsel & !hwrite)
    begin
      unique case (haddr[7:0])
        cpkl_pkg::A_CTRL: hrdata_d = {27'h0, ctrl_q};
        cpkl_pkg::A_STAT: hrdata_d = {24'h0, stat};
        cpkl_pkg::A_IRQ:  hrdata_d = {28'h0, irq_q};
        cpkl_pkg::A_MASK: hrdata_d = {28'h0, mask_q};
        cpkl_pkg::A_ISRH: hrdata_d = isr_q[63:32];
        cpkl_pkg::A_ISRL: hrdata_d = isr_q[31:0];
        cpkl_pkg::A_OSRH: hrdata_d = osr_q[63:32];
        cpkl_pkg::A_OSRL: hrdata_d = osr_q[31:0];
        cpkl_pkg::A_KEYH: hrdata_d = {8'h00, key_q[55:32]};
        cpkl_pkg::A_KEYL: hrdata_d = key_q[31:0];
        default:          hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= cpkl_pkg::CTRL_RST;
      instr_q <= '0;
      pend_q <= 1'b0;
      ph_q <= 1'b0;
      kreq_q <= 1'b0;
      act_q <= 1'b0;
      pf_q <= 1'b0;
      bad_q <= 1'b0;
      gpar_q <= 1'b0;
      key_q <= '0;
      kcnt_q <= '0;
      isr_q <= '0;
      icnt_q <= '0;
      isrf_q <= 1'b0;
      osr_q <= '0;
      ocnt_q <= '0;
      osre_q <= 1'b1;
      osrh_q <= '0;
      irq_q <= '0;
      mask_q <= '0;
      wa_q <= '0;
      wr_q <= 1'b0;
      hrdata_q <= '0;
      spo_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      instr_q <= instr_d;
      pend_q <= pend_d;
      ph_q <= ph_d;
      kreq_q <= kreq_d;
      act_q <= act_d;
      pf_q <= pf_d;
      bad_q <= bad_d;
      gpar_q <= gpar_d;
      key_q <= key_d;
      kcnt_q <= kcnt_d;
      isr_q <= isr_d;
      icnt_q <= icnt_d;
      isrf_q <= isrf_d;
      osr_q <= osr_d;
      ocnt_q <= ocnt_d;
      osre_q <= osre_d;
      osrh_q <= osrh_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
      wa_q <= wa_d;
      wr_q <= wr_d;
      hrdata_q <= hrdata_d;
      spo_q <= spo_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_q & mask_q);
  assign key_request_n = !kreq_q;  // RULE_01
  assign active = act_q;  // RULE_02
  assign parity_fail_n = !pf_q;  // RULE_03
  assign slave_flag = ctrl_q[cpkl_pkg::C_ISR_SLV] ? isrf_q : osre_q;  // RULE_09
  assign master_flag_a = ctrl_q[cpkl_pkg::C_OSR_SLV] ? isrf_q
                         : (ctrl_q[cpkl_pkg::C_ISR_SLV] ? osre_q : !osre_q);
  assign master_flag_b = isrf_q;
  assign slave_par_bus_o = spo_q;
  assign slave_par_bus_oe = sel & !s2_q.s_rd_n & !ctrl_q[cpkl_pkg::C_S_SER];  // RULE_16
  assign slave_serial_io_o = osr_q[63];  // RULE_08
  assign slave_serial_io_oe = sel & !s2_q.s_rd_n & ctrl_q[cpkl_pkg::C_S_SER]
                              & ctrl_q[cpkl_pkg::C_OSR_SLV];  // RULE_16
  assign master_serial_io_o = osr_q[63];
  assign master_serial_io_oe = m_a0 & !s2_q.m_rd_n & ctrl_q[cpkl_pkg::C_M_SER]
                               & !ctrl_q[cpkl_pkg::C_OSR_SLV];  // RULE_10

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_kreq;
    exec && instr_q[cpkl_pkg::I_SERIAL] && instr_q[cpkl_pkg::I_ACT]
      && !instr_q[cpkl_pkg::I_END] |=> !key_request_n && kcnt_q == 7'h00;
  endproperty
  a_kreq: assert property (p_kreq) else $error("key request not raised"); // RULE_01
  property p_act;
    $rose(active) |-> $past(exec) && $past(instr_q[cpkl_pkg::I_ACT]);
  endproperty
  a_act: assert property (p_act) else $error("active set without act"); // RULE_02
  property p_pf;
    $changed(parity_fail_n) |-> $past(pf_upd);
  endproperty
  a_pf: assert property (p_pf) else $error("parity flag moved off update"); // RULE_04
  property p_last;
    k_take && kcnt_q == 7'h3F |=> kcnt_q == 7'h40 && key_request_n;
  endproperty
  a_last: assert property (p_last) else $error("64th key clock mishandled"); // RULE_15
  property p_hold;
    !kreq_q && !ctrl_q[cpkl_pkg::C_KEY_PAR] |=> $stable(key_q);
  endproperty
  a_hold: assert property (p_hold) else $error("key changed while idle"); // RULE_11
  property p_phase;
    exec |=> !exec;
  endproperty
  a_phase: assert property (p_phase) else $error("two instructions back to back"); // RULE_05
  property p_even;
    k_take && grp_end && !(gpar_q ^ s2_q.k_dat) |=> bad_q || kcnt_q == 7'h40;
  endproperty
  a_even: assert property (p_even) else $error("even group not caught"); // RULE_18
  property p_msb;
    isr_wr && !isrf_q && ser_in |=> isr_q[0] == $past(in_bit)
      && isr_q[63:1] == $past(isr_q[62:0]);
  endproperty
  a_msb: assert property (p_msb) else $error("serial shift order wrong"); // RULE_08
  property p_tri;
    s2_q.s_sel_n |-> !slave_par_bus_oe && !slave_serial_io_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("slave drives while deselected"); // RULE_16
  c_keyd: cover property (pf_upd && k_take);
  c_pfail: cover property ($fell(parity_fail_n));
  c_isrf: cover property ($rose(isrf_q));
  c_osre: cover property ($rose(osre_q));
endmodule
`default_nettype wire

//--- test/cpkl_host_model.sv
// host-side pin model: strobes, serial data and serial key clock
`default_nettype none
module cpkl_host_model (
  input  wire logic       clk,            // bench clock
  input  wire logic [7:0] s_par_w,        // slave bus wire
  input  wire logic       s_ser_w,        // slave serial wire
  input  wire logic       m_ser_w,        // master serial wire
  output logic            slave_wr_n,     // slave write strobe
  output logic            slave_rd_n,     // slave read strobe
  output logic            master_wr_n,    // master write strobe
  output logic            master_rd_n,    // master read strobe
  output logic            key_serial_clk, // key clock, idle high
  output logic            key_serial_in,  // key data
  output logic [7:0]      s_par_d,        // slave bus drive
  output logic [7:0]      m_par_d,        // master bus drive
  output logic            s_ser_d,        // slave serial drive
  output logic            m_ser_d         // master serial drive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {slave_wr_n, slave_rd_n, master_wr_n, master_rd_n, key_serial_clk} = 5'h1F;
    {key_serial_in, s_ser_d, m_ser_d} = 3'h0;
    s_par_d = 8'h00;
    m_par_d = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one key bit, clock stands high between bits
  task automatic key_bit(input logic b);
    key_serial_in <= b;
    repeat (4) @(posedge clk);
    key_serial_clk <= 1'b0;
    repeat (4) @(posedge clk);
    key_serial_clk <= 1'b1;
  endtask
  // strobe low 6 clk, high 6 clk, data held 3 clk past release
  task automatic pulse(input int w, input logic [7:0] d, output logic [7:0] pv,
                       output logic sv);
    s_par_d <= d;
    m_par_d <= d;
    s_ser_d <= d[7];
    m_ser_d <= d[7];
    case (w)
      0: slave_wr_n <= 1'b0;
      1: slave_rd_n <= 1'b0;
      2: master_wr_n <= 1'b0;
      default: master_rd_n <= 1'b0;
    endcase
    repeat (6) @(posedge clk);
    pv = s_par_w;
    sv = (w < 2) ? s_ser_w : m_ser_w;
    {slave_wr_n, slave_rd_n, master_wr_n, master_rd_n} <= 4'hF;
    repeat (3) @(posedge clk);
    s_par_d <= ~d;
    m_par_d <= ~d;
    s_ser_d <= ~d[7];
    m_ser_d <= ~d[7];
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- test/cipher_port_key_loader_tb.sv
// self-checking bench for the cipher port and key loader
`default_nettype none
module cipher_port_key_loader_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rv, rl;
  logic [1:0]  htrans;
  logic [2:0]  hsize, master_addr;
  logic        slave_select_n, slave_addr, slave_flag, master_flag_a, master_flag_b;
  logic        slave_wr_n, slave_rd_n, master_wr_n, master_rd_n, key_clk, key_dat;
  logic        s_ser_o, s_ser_oe, m_ser_o, m_ser_oe, s_ser_d, m_ser_d, sv;
  logic        key_request_n, active, parity_fail_n, s_par_oe;
  logic [7:0]  s_par_o, s_par_d, m_par_d, pv;
  logic [63:0] kv, got;
  wire  [7:0]  s_par_w = s_par_oe ? s_par_o : s_par_d;
  wire         s_ser_w = s_ser_oe ? s_ser_o : s_ser_d;
  wire         m_ser_w = m_ser_oe ? m_ser_o : m_ser_d;
  int          failures = 0;
  int          samples_checked = 0;
  localparam logic [55:0] K1   = 56'h12_3456_789A_BCDE;
  localparam logic [55:0] K2   = 56'hF0_E1D2_C3B4_A596;
  localparam logic [63:0] PAT  = 64'hA5C3_0F96_1E2D_B478;
  localparam logic [63:0] OPAT = 64'h8001_7FFE_C33C_5AA5;
  always #25 clk = ~clk;
  cpkl_top u_cpkl_top (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .slave_wr_n(slave_wr_n),
    .slave_rd_n(slave_rd_n), .slave_select_n(slave_select_n), .slave_addr(slave_addr),
    .slave_flag(slave_flag), .slave_par_bus_i(s_par_w), .slave_par_bus_o(s_par_o),
    .slave_par_bus_oe(s_par_oe), .slave_serial_io_i(s_ser_w), .slave_serial_io_o(s_ser_o),
    .slave_serial_io_oe(s_ser_oe), .master_wr_n(master_wr_n), .master_rd_n(master_rd_n),
    .master_addr(master_addr), .master_par_in(m_par_d), .master_flag_a(master_flag_a),
    .master_flag_b(master_flag_b), .master_serial_io_i(m_ser_w),
    .master_serial_io_o(m_ser_o), .master_serial_io_oe(m_ser_oe), .key_serial_in(key_dat),
    .key_serial_clk(key_clk), .key_request_n(key_request_n), .active(active),
    .parity_fail_n(parity_fail_n));
  cpkl_host_model u_cpkl_host_model (.clk(clk), .s_par_w(s_par_w), .s_ser_w(s_ser_w),
    .m_ser_w(m_ser_w), .slave_wr_n(slave_wr_n), .slave_rd_n(slave_rd_n),
    .master_wr_n(master_wr_n), .master_rd_n(master_rd_n), .key_serial_clk(key_clk),
    .key_serial_in(key_dat), .s_par_d(s_par_d), .m_par_d(m_par_d), .s_ser_d(s_ser_d),
    .m_ser_d(m_ser_d));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      stop_test;
    end
  endtask
  task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait;
    rd = hrdata;
  endtask
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb_xfer(a, 1'b1, d, x);
  endtask
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    ahb_xfer(a, 1'b0, 32'h0000_0000, d);
  endtask
  // seven data bits then odd parity, one byte optionally spoiled
  function automatic logic [63:0] mkkey(input logic [55:0] k, input int bad);
    logic [63:0] v;
    for (int i = 0; i < 8; i++)
      v[63-8*i -: 8] = {k[55-7*i -: 7], (~^k[55-7*i -: 7]) ^ (i == bad)};
    return v;
  endfunction
  task automatic send_key(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++)
      u_cpkl_host_model.key_bit(v[63-i]);
    repeat (6) @(posedge clk);
  endtask
  task automatic rd_key(input logic [55:0] k);
    ahb_rd(cpkl_pkg::A_KEYH, rv);
    ahb_rd(cpkl_pkg::A_KEYL, rl);
    chk("key memory", {rv[23:0], rl}, k);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    stop_test;
  end
  initial
  begin
    {nrst, hsel, hwrite, slave_addr, htrans, master_addr} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'b010;
    slave_select_n = 1'b1;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset pins", {key_request_n, active, parity_fail_n, s_par_oe, s_ser_oe, hresp},
        6'b101000);
    ahb_rd(8'h40, rv);
    chk("unmapped", rv, 32'h0000_0000);
    ahb_wr(cpkl_pkg::A_MASK, 32'h0000_0000);
    ahb_wr(cpkl_pkg::A_INSTR, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk("request and active", {key_request_n, active}, 2'b01);
    ahb_rd(cpkl_pkg::A_STAT, rv);
    chk("status request active", {rv[6], rv[3]}, 2'b11);
    send_key(mkkey(K1, 8), 64);
    chk("good key flags", {key_request_n, parity_fail_n, irq}, 3'b110);
    rd_key(K1);
    send_key(64'hFFFF_FFFF_FFFF_FFFF, 8);
    rd_key(K1);
    ahb_wr(cpkl_pkg::A_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("irq unmasked", irq, 1'b1);
    ahb_wr(cpkl_pkg::A_IRQ, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    ahb_wr(cpkl_pkg::A_CTRL, 32'h0000_0000);
    ahb_wr(cpkl_pkg::A_INSTR, 32'h0000_0003);
    repeat (3) @(posedge clk);
    send_key(mkkey(K2, 2), 64);
    chk("bad parity pin", parity_fail_n, 1'b0);
    ahb_rd(cpkl_pkg::A_STAT, rv);
    chk("bad parity status", rv[7], 1'b1);
    rd_key(K2);
    ahb_wr(cpkl_pkg::A_CTRL, 32'h0000_0010);
    kv = mkkey(K1, 8);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        chk("before 8th byte", parity_fail_n, 1'b0);
      u_cpkl_host_model.pulse(2, kv[63-8*i -: 8], pv, sv);
    end
    repeat (4) @(posedge clk);
    chk("after 8th byte", parity_fail_n, 1'b1);
    rd_key(K1);
    slave_select_n <= 1'b0;
    ahb_wr(cpkl_pkg::A_CTRL, 32'h0000_0005);
    ahb_wr(cpkl_pkg::A_INSTR, 32'h0000_0008);
    repeat (3) @(posedge clk);
    for (int i = 63; i >= 0; i--)
      u_cpkl_host_model.pulse(0, {PAT[i], 7'h00}, pv, sv);
    repeat (4) @(posedge clk);
    chk("slave flag full", slave_flag, 1'b1);
    chk("master flag b", master_flag_b, 1'b1);
    ahb_rd(cpkl_pkg::A_ISRH, rv);
    ahb_rd(cpkl_pkg::A_ISRL, rl);
    chk("input register", {rv, rl}, PAT);
    ahb_wr(cpkl_pkg::A_CTRL, 32'h0000_0008);
    ahb_wr(cpkl_pkg::A_OSRH, OPAT[63:32]);
    ahb_wr(cpkl_pkg::A_OSRL, OPAT[31:0]);
    repeat (2) @(posedge clk);
    chk("osr full flag", master_flag_a, 1'b1);
    master_addr <= 3'h1;
    u_cpkl_host_model.pulse(3, 8'hFF, pv, sv);
    master_addr <= 3'h0;
    for (int i = 63; i >= 0; i--)
      u_cpkl_host_model.pulse(3, 8'hFF, pv, got[i]);
    chk("output serial", got, OPAT);
    ahb_rd(cpkl_pkg::A_STAT, rv);
    chk("osr empty", {rv[5], master_flag_a}, 2'b10);
    slave_addr <= 1'b1;
    u_cpkl_host_model.pulse(1, 8'hFF, pv, sv);
    chk("slave status bus", pv & 8'hE8, 8'h60);
    slave_select_n <= 1'b1;
    u_cpkl_host_model.pulse(1, 8'hFF, pv, sv);
    chk("deselected bus", pv & 8'hE8, 8'hE8);
    stop_test;
  end
endmodule
`default_nettype wire
